/* File: port_loop_params.svh */
// Constants for the port loopback control block
`ifndef PORT_LOOP_PARAMS_SVH
`define PORT_LOOP_PARAMS_SVH

// Loopback selection codes
`define LOOP_SEL_NONE     2'h0
`define LOOP_SEL_FACILITY 2'h1
`define LOOP_SEL_TERMINAL 2'h2

// Default sizes
`define NUM_CLIENTS_DEF   4
`define DATA_W_DEF        8
`define FIFO_DEPTH_DEF    8

// Word sent in place of traffic when path alarm indication is forced
`define PATH_AIS_FILL     1'b1

// Reset value of the loopback selection of each port
`define LOOP_SEL_RESET    2'h0

`endif

/* File: port_loop_pkg.sv */
// Types shared by the port loopback control files
`include "port_loop_params.svh"

package port_loop_pkg;

   // Loopback selection of one port; the unused code reads as none
   typedef enum logic [1:0] {
      LOOP_NONE     = `LOOP_SEL_NONE,
      LOOP_FACILITY = `LOOP_SEL_FACILITY,
      LOOP_TERMINAL = `LOOP_SEL_TERMINAL
   } loop_sel_t;

endpackage

/* File: loop_fifo.sv */
// Small flip-flop FIFO carrying trunk-bound words
`timescale 1ns/1ps
`default_nettype none

module loop_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   ////////////////////////////////////////////////////////////////////////
   // Honest flags; full stalls the writer, empty stalls the reader
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   ////////////////////////////////////////////////////////////////////////
   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers wrap at DEPTH, which need not be a power of two
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // Occupancy
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + 1'b1;
      end else if (pop && !push) begin
         count <= count - 1'b1;
      end
   end

endmodule

`default_nettype wire

/* File: port_loop_status.sv */
// Per-port loopback decode, conditions and alarm suppression
`timescale 1ns/1ps
`default_nettype none
`include "port_loop_params.svh"

module port_loop_status
   import port_loop_pkg::*;
#(
   parameter int NP = 5
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic [2*NP-1:0] loop_sel,
   input  wire logic [NP-1:0]   loop_permit,
   input  wire logic [NP-1:0]   alarm_raw,
   input  wire logic            alarm_in_loop,
   output logic      [NP-1:0]   term_active,
   output logic      [NP-1:0]   fac_active,
   output logic      [NP-1:0]   terminal_loop_condition,
   output logic      [NP-1:0]   line_loop_condition,
   output logic      [NP-1:0]   alarms_suppressed_maint,
   output logic      [NP-1:0]   out_of_service_loop_maint,
   output logic      [NP-1:0]   alarm_out
);

   // One decode per port; the spare code falls back to no loopback
   function automatic loop_sel_t decode_sel(input logic [1:0] code);
      case (code)
         `LOOP_SEL_FACILITY: decode_sel = LOOP_FACILITY;
         `LOOP_SEL_TERMINAL: decode_sel = LOOP_TERMINAL;
         default:            decode_sel = LOOP_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_port
         loop_sel_t sel;
         logic      any;

         // A single field per port means only one type can be active
         assign sel = decode_sel(loop_sel[2*g +: 2]);
         assign term_active[g] = loop_permit[g] && (sel == LOOP_TERMINAL);
         assign fac_active[g]  = loop_permit[g] && (sel == LOOP_FACILITY);
         assign any = term_active[g] || fac_active[g];

         // Registered report of each port's loopback and alarm view
         always_ff @(posedge clk) begin
            if (rst) begin
               terminal_loop_condition[g]   <= 1'b0;
               line_loop_condition[g]       <= 1'b0;
               alarms_suppressed_maint[g]   <= 1'b0;
               out_of_service_loop_maint[g] <= 1'b0;
               alarm_out[g]                 <= 1'b0;
            end else begin
               terminal_loop_condition[g]   <= term_active[g];
               line_loop_condition[g]       <= fac_active[g];
               alarms_suppressed_maint[g]   <= any && !alarm_in_loop;
               out_of_service_loop_maint[g] <= any;
               alarm_out[g] <= alarm_raw[g] && (!any || alarm_in_loop);
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* File: port_loopback_control.sv */
// Loopback datapath control between client ports and one trunk port
//
// Contract
// - Client terminal loop returns trunk traffic back toward the trunk.
// - Trunk terminal loop returns client traffic back to that client.
// - Turnaround sits inside the card, never through the looped line interface.
// - A terminating port loops back only and forwards nothing downstream.
// - A bridging port loops back and still forwards; terminal loops bridge.
// - Terminated loop injects alarm indication downstream; bridged loop injects none (here bridged client terminal and trunk facility loops force AIS/squelch).
// - Add-drop client terminal loop sends path alarm indication on SONET clients.
// - Add-drop client terminal loop squelches an Ethernet client output.
// - Add-drop trunk facility loop sends path alarm indication on SONET clients.
// - Add-drop trunk facility loop squelches every Ethernet client.
// - Add-drop trunk terminal loop keeps sending downstream, drop and continue.
// - Trunk terminal loop acts on the aggregate, affecting every client; only clients with in_service_normal set are looped.
// - Per-port status tells terminal loopback apart from facility loopback.
// - Port alarms suppressed during loopback unless alarm-in-loop is set.
// - Clients map statically to trunk slots; no cross-connect needed.
// - Single-client transponder: client looped in maintenance, trunk in service.
// - Trunk terminal loop: trunk in maintenance, clients in service to loop.
`timescale 1ns/1ps
`default_nettype none
`include "port_loop_params.svh"

module port_loopback_control
   import port_loop_pkg::*;
#(
   parameter int NUM_CLIENTS   = `NUM_CLIENTS_DEF,
   parameter int DATA_W        = `DATA_W_DEF,
   parameter int FIFO_DEPTH    = `FIFO_DEPTH_DEF,
   parameter bit ADD_DROP      = 1'b1,
   parameter bit SINGLE_CLIENT = 1'b0,
   parameter int PW = (NUM_CLIENTS > 1) ? $clog2(NUM_CLIENTS) : 1
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   // Configuration; index NUM_CLIENTS is the trunk
   input  wire logic [2*NUM_CLIENTS+1:0]   loop_sel,
   input  wire logic [NUM_CLIENTS:0]       loop_terminate,
   input  wire logic [NUM_CLIENTS:0]       port_maint,
   input  wire logic [NUM_CLIENTS:0]       in_service_normal,
   input  wire logic [NUM_CLIENTS-1:0]     client_is_eth,
   input  wire logic                       alarm_in_loop,
   input  wire logic [NUM_CLIENTS:0]       alarm_raw,
   // Traffic received from the client line interfaces
   input  wire logic                       client_rx_valid,
   output logic                            client_rx_ready,
   input  wire logic [PW-1:0]              client_rx_port,
   input  wire logic [DATA_W-1:0]          client_rx_data,
   // Traffic sent to the client line interfaces
   output logic                            client_tx_valid,
   output logic      [PW-1:0]              client_tx_port,
   output logic      [DATA_W-1:0]          client_tx_data,
   output logic      [NUM_CLIENTS-1:0]     client_squelch,
   output logic      [NUM_CLIENTS-1:0]     path_alarm_indication,
   // Aggregate traffic received from the trunk line interface
   input  wire logic                       trunk_rx_valid,
   output logic                            trunk_rx_ready,
   input  wire logic [PW-1:0]              trunk_rx_port,
   input  wire logic [DATA_W-1:0]          trunk_rx_data,
   // Aggregate traffic sent to the trunk line interface
   output logic                            trunk_tx_valid,
   input  wire logic                       trunk_tx_ready,
   output logic      [PW-1:0]              trunk_tx_port,
   output logic      [DATA_W-1:0]          trunk_tx_data,
   // Status
   output logic      [NUM_CLIENTS:0]       terminal_loop_condition,
   output logic      [NUM_CLIENTS:0]       line_loop_condition,
   output logic      [NUM_CLIENTS:0]       alarms_suppressed_maint,
   output logic      [NUM_CLIENTS:0]       out_of_service_loop_maint,
   output logic      [NUM_CLIENTS:0]       alarm_out
);

   localparam int NP = NUM_CLIENTS + 1;
   localparam int TR = NUM_CLIENTS;
   localparam int FW = PW + DATA_W;
   localparam logic [DATA_W-1:0] AIS_WORD = {DATA_W{`PATH_AIS_FILL}};

   logic [NP-1:0]          loop_permit;
   logic [NP-1:0]          term_active;
   logic [NP-1:0]          fac_active;
   logic [NUM_CLIENTS-1:0] force_ais;
   logic [NUM_CLIENTS-1:0] force_squelch;
   logic                   trunk_term;
   logic                   trunk_fac_term;
   logic                   t_loop;
   logic                   t_fwd;
   logic                   c_loop;
   logic                   c_take;
   logic                   fifo_in_valid;
   logic                   fifo_in_ready;
   logic [FW-1:0]          fifo_in_data;
   logic [FW-1:0]          fifo_out_data;
   logic [DATA_W-1:0]      c_up_data;
   logic                   next_tx_valid;
   logic [PW-1:0]          next_tx_port;
   logic [DATA_W-1:0]      next_tx_data;

   ////////////////////////////////////////////////////////////////////////
   // Loopbacks only take effect on a port the controller put in
   // maintenance; a lone client loop also needs the trunk in service
   always_comb begin
      loop_permit = port_maint;
      if (SINGLE_CLIENT && !in_service_normal[TR]) begin
         loop_permit[NUM_CLIENTS-1:0] = '0;
      end
   end

   // Per-port decode and reporting
   port_loop_status #(
      .NP (NP)
   ) u_status (
      .clk                       (clk),
      .rst                       (rst),
      .loop_sel                  (loop_sel),
      .loop_permit               (loop_permit),
      .alarm_raw                 (alarm_raw),
      .alarm_in_loop             (alarm_in_loop),
      .term_active               (term_active),
      .fac_active                (fac_active),
      .terminal_loop_condition   (terminal_loop_condition),
      .line_loop_condition       (line_loop_condition),
      .alarms_suppressed_maint   (alarms_suppressed_maint),
      .out_of_service_loop_maint (out_of_service_loop_maint),
      .alarm_out                 (alarm_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Client-facing alarm and squelch treatment
   assign trunk_term     = term_active[TR];
   assign trunk_fac_term = fac_active[TR] && loop_terminate[TR];

   genvar g;
   generate
      for (g = 0; g < NUM_CLIENTS; g++) begin : g_client
         logic hit;
         // Client terminal loop or trunk facility loop on the add-drop card
         assign hit = ADD_DROP && (term_active[g] || fac_active[TR]);
         // SONET clients get path alarm; a terminated trunk facility loop hits all
         assign force_ais[g] = (hit && !client_is_eth[g])
                               || trunk_fac_term;
         // Ethernet clients are shut rather than filled
         assign force_squelch[g] = hit && client_is_eth[g];
      end
   endgenerate

   // Level outputs, registered so they stand clean for the line side
   always_ff @(posedge clk) begin
      if (rst) begin
         client_squelch        <= '0;
         path_alarm_indication <= '0;
      end else begin
         client_squelch        <= force_squelch;
         path_alarm_indication <= force_ais & ~force_squelch;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trunk receive: slot number is the client number, fixed mapping
   // Turnaround sits here in the card logic, before any line interface
   assign t_loop = trunk_rx_valid && term_active[trunk_rx_port];
   // A trunk terminal loop takes the aggregate, so slots whose client is
   // in service are looped and the trunk data to them is dropped
   assign t_fwd = trunk_rx_valid && !(trunk_term && in_service_normal[trunk_rx_port])
                  && !(fac_active[TR] && loop_terminate[TR]);
   // Looped words need FIFO room; plain forwarding never stalls
   assign trunk_rx_ready = !t_loop || fifo_in_ready;

   ////////////////////////////////////////////////////////////////////////
   // Client receive toward trunk; loop to clients only when in service
   assign c_loop = trunk_term && in_service_normal[client_rx_port];
   // Looped trunk words win the FIFO; the client source is held off
   assign client_rx_ready = fifo_in_ready && !t_loop;
   assign c_take = client_rx_valid && client_rx_ready;

   // A terminated client facility loop sends alarm fill instead of data
   always_comb begin
      c_up_data = client_rx_data;
      if (fac_active[client_rx_port] && loop_terminate[client_rx_port]) begin
         c_up_data = AIS_WORD;
      end
   end

   // FIFO feed; terminal loops always bridge, so looped client data also
   // still goes up the trunk
   always_comb begin
      fifo_in_valid = 1'b0;
      fifo_in_data  = {client_rx_port, c_up_data};
      if (t_loop) begin
         fifo_in_valid = 1'b1;
         fifo_in_data  = {trunk_rx_port, trunk_rx_data};
      end else if (client_rx_valid) begin
         fifo_in_valid = 1'b1;
      end
   end

   // The trunk line side can stall; backpressure reaches both sources
   loop_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_trunk_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (trunk_tx_valid),
      .out_ready (trunk_tx_ready),
      .out_data  (fifo_out_data)
   );

   assign trunk_tx_port = fifo_out_data[FW-1 -: PW];
   assign trunk_tx_data = fifo_out_data[DATA_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Client transmit selection. Trunk loop and trunk forwarding cannot
   // collide on one port: a looped client drops its trunk slot.
   always_comb begin
      next_tx_valid = 1'b0;
      next_tx_port  = trunk_rx_port;
      next_tx_data  = trunk_rx_data;
      if (c_take && c_loop) begin
         next_tx_valid = 1'b1;
         next_tx_port  = client_rx_port;
         next_tx_data  = client_rx_data;
      end else if (t_fwd && trunk_rx_ready) begin
         next_tx_valid = 1'b1;
      end
      if (force_ais[next_tx_port]) begin
         next_tx_data = AIS_WORD;
      end
      if (force_squelch[next_tx_port]) begin
         next_tx_valid = 1'b0;
      end
   end

   // Client words leave from flip-flops, one cycle after acceptance
   always_ff @(posedge clk) begin
      if (rst) begin
         client_tx_valid <= 1'b0;
         client_tx_port  <= '0;
         client_tx_data  <= '0;
      end else begin
         client_tx_valid <= next_tx_valid;
         client_tx_port  <= next_tx_port;
         client_tx_data  <= next_tx_data;
      end
   end

endmodule

`default_nettype wire

/* File: port_loop_chk.sv */
// Port-level assertions for the loopback control block
`timescale 1ns/1ps
`default_nettype none

module port_loop_chk #(
   parameter int N      = 4,
   parameter int DATA_W = 8,
   parameter int PW     = 2
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic [2*N+1:0]    loop_sel,
   input wire logic [N:0]        port_maint,
   input wire logic [N:0]        in_service_normal,
   input wire logic [N-1:0]      client_is_eth,
   input wire logic              alarm_in_loop,
   input wire logic [N:0]        alarm_raw,
   input wire logic              client_rx_valid,
   input wire logic              client_rx_ready,
   input wire logic [PW-1:0]     client_rx_port,
   input wire logic [DATA_W-1:0] client_rx_data,
   input wire logic              client_tx_valid,
   input wire logic [PW-1:0]     client_tx_port,
   input wire logic [DATA_W-1:0] client_tx_data,
   input wire logic [N-1:0]      client_squelch,
   input wire logic [N-1:0]      path_alarm_indication,
   input wire logic              trunk_tx_valid,
   input wire logic              trunk_tx_ready,
   input wire logic [PW-1:0]     trunk_tx_port,
   input wire logic [DATA_W-1:0] trunk_tx_data,
   input wire logic [N:0]        terminal_loop_condition,
   input wire logic [N:0]        line_loop_condition,
   input wire logic [N:0]        out_of_service_loop_maint,
   input wire logic [N:0]        alarm_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////
   // Status follows the selection one cycle later
   a_trunk_term: assert property (
      loop_sel[2*N+1 -: 2] == 2'h2 && port_maint[N] |=> terminal_loop_condition[N]
      && !line_loop_condition[N]) else $error("trunk terminal status wrong");
   a_fac_state: assert property (
      loop_sel[1:0] == 2'h1 && port_maint[0] |=> line_loop_condition[0]
      && !terminal_loop_condition[0]) else $error("facility status wrong");
   a_oos_loop: assert property (
      out_of_service_loop_maint == (terminal_loop_condition | line_loop_condition))
      else $error("maintenance state does not track loop");
   a_no_maint: assert property (
      !port_maint[1] |=> !terminal_loop_condition[1] && !line_loop_condition[1])
      else $error("loop active without maintenance");
   // Alarms hidden in loopback, visible otherwise
   a_alarm_mask: assert property (
      alarm_raw[N] && !alarm_in_loop && loop_sel[2*N+1 -: 2] == 2'h1 && port_maint[N]
      |=> !alarm_out[N]) else $error("alarm not suppressed in loop");
   a_alarm_pass: assert property (
      alarm_raw[0] && loop_sel[1:0] == 2'h0 |=> alarm_out[0])
      else $error("alarm lost outside loop");
   // Trunk facility loop: AIS on SONET clients, squelch on Ethernet
   a_fac_squelch: assert property (
      loop_sel[2*N+1 -: 2] == 2'h1 && port_maint[N] && loop_sel[2*N-1:0] == '0
      |=> client_squelch == $past(client_is_eth)) else $error("squelch wrong");
   a_fac_ais: assert property (
      loop_sel[2*N+1 -: 2] == 2'h1 && port_maint[N] && loop_sel[2*N-1:0] == '0
      |=> path_alarm_indication == ~$past(client_is_eth)) else $error("path AIS wrong");
   // Datapath: static mapping, word held under stall, drop and continue
   a_route_trunk: assert property (
      client_rx_valid && client_rx_ready && !trunk_tx_valid && loop_sel == '0
      |=> trunk_tx_valid && trunk_tx_port == $past(client_rx_port)
      && trunk_tx_data == $past(client_rx_data)) else $error("client word misrouted");
   a_hold_word: assert property (
      trunk_tx_valid && !trunk_tx_ready |=> trunk_tx_valid && $stable(trunk_tx_data)
      && $stable(trunk_tx_port)) else $error("trunk word dropped under stall");
   a_drop_cont: assert property (
      client_rx_valid && client_rx_ready && terminal_loop_condition[N] && port_maint[N]
      && loop_sel[2*N+1 -: 2] == 2'h2 && loop_sel[2*N-1:0] == '0 && &in_service_normal
      |=> client_tx_valid && client_tx_port == $past(client_rx_port)
      && client_tx_data == $past(client_rx_data)) else $error("trunk loop copy missing");

   c_trunk_loop: cover property (terminal_loop_condition[N] && client_tx_valid);
   c_fifo_stall: cover property ((trunk_tx_valid && !trunk_tx_ready) [*3]);
   c_squelch: cover property (|client_squelch && |path_alarm_indication);
endmodule

bind port_loopback_control port_loop_chk #(.N(NUM_CLIENTS), .DATA_W(DATA_W), .PW(PW)) u_chk (.*);

`default_nettype wire

/* File: trunk_line_model.sv */
// Trunk line interface model: sinks trunk words with a chosen stall pattern
`timescale 1ns/1ps
`default_nettype none

module trunk_line_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] stall,
   output logic            trunk_tx_ready
);
   logic [2:0] tick;

   // Free-running phase; tick moves on the edge, but ready follows stall at once, mid-cycle when the bench changes it
   always_ff @(posedge clk) begin
      if (rst) begin
         tick <= 3'h0;
      end else begin
         tick <= tick + 3'h1;
      end
   end

   // 0 takes all, 1 blocks, 2 stalls on an uneven pattern to catch holding bugs
   assign trunk_tx_ready = (stall == 2'h0) || (stall == 2'h2 && tick != 3'h2 && tick != 3'h5);
endmodule

`default_nettype wire

/* File: port_loopback_control_test.sv */
// Self-checking bench for the port loopback control block
`timescale 1ns/1ps
`default_nettype none

module port_loopback_control_test;
   import port_loop_pkg::*;
   logic        clk, rst, alarm_in_loop, client_rx_valid, client_rx_ready, t, f;
   logic        client_tx_valid, trunk_rx_valid, trunk_rx_ready, trunk_tx_valid, trunk_tx_ready;
   logic [1:0]  client_rx_port, client_tx_port, trunk_rx_port, trunk_tx_port, stall;
   logic [3:0]  client_is_eth, client_squelch, path_alarm_indication;
   logic [4:0]  loop_terminate, port_maint, in_service_normal, alarm_raw, alarm_out;
   logic [4:0]  terminal_loop_condition, line_loop_condition, alarms_suppressed_maint;
   logic [4:0]  out_of_service_loop_maint;
   logic [7:0]  client_rx_data, client_tx_data, trunk_rx_data, trunk_tx_data, d;
   logic [9:0]  loop_sel, q_trk[$], q_cli[$];
   logic [31:0] rnd;
   int          err_total, n_tests, cyc;

   port_loopback_control u_port_loopback_control (.*);
   trunk_line_model u_trunk_line_model (.*);

   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [7:0] nxt();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd[7:0];
   endfunction

   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Maintenance goes on a cycle before the loop selection, as a controller would
   task automatic cfg(input logic [9:0] s, input logic [4:0] m, input logic [4:0] tm);
      @(posedge clk) #1 port_maint = m;
      loop_terminate = tm;
      @(posedge clk) #1 loop_sel = s;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // One word in; ex[0] notes a trunk word td, ex[1] a client word cd
   task automatic send(input logic tr, input logic [1:0] p, input logic [7:0] dd,
                       input logic [1:0] ex, input logic [7:0] td, input logic [7:0] cd);
      @(posedge clk) #1;
      if (tr) {trunk_rx_valid, trunk_rx_port, trunk_rx_data} = {1'b1, p, dd};
      else {client_rx_valid, client_rx_port, client_rx_data} = {1'b1, p, dd};
      @(negedge clk);
      while (!(tr ? trunk_rx_ready : client_rx_ready)) @(negedge clk);
      @(posedge clk);
      if (ex[0]) q_trk.push_back({p, td});
      if (ex[1]) q_cli.push_back({p, cd});
      #1 {trunk_rx_valid, client_rx_valid} = 2'h0;
      {trunk_rx_data, client_rx_data} = ~{trunk_rx_data, client_rx_data};
   endtask

   task automatic drain();
      for (int i = 0; i < 100 && q_trk.size() + q_cli.size() != 0; i++) @(posedge clk);
      chk(10'(q_trk.size() + q_cli.size()), 10'h0);
   endtask

   // Scoreboard: oldest note is compared whenever a word leaves the block
   always @(posedge clk) begin
      if (!rst && trunk_tx_valid && trunk_tx_ready) begin
         chk({trunk_tx_port, trunk_tx_data}, q_trk.size() ? q_trk.pop_front() : 10'hXXX);
      end
      if (!rst && client_tx_valid) begin
         chk({client_tx_port, client_tx_data}, q_cli.size() ? q_cli.pop_front() : 10'hXXX);
      end
   end

   // Hang guard, generous against a run of well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end

   ////////////////////////////////////////
   initial begin
      {client_rx_valid, client_rx_port, client_rx_data, trunk_rx_valid} = '0;
      {trunk_rx_port, trunk_rx_data, loop_sel, loop_terminate, port_maint} = '0;
      {alarm_in_loop, alarm_raw, stall} = '0;
      in_service_normal = 5'h1F;
      client_is_eth = 4'h5;
      rnd = 32'h60;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      chk({terminal_loop_condition, line_loop_condition}, 10'h0);
      // Trunk blocked: eight words fill the buffer, then it refuses
      stall = 2'h1;
      for (int i = 0; i < 8; i++) begin
         d = nxt();
         send(1'b0, rnd[9:8], d, 2'h1, d, d);
      end
      // Full buffer holds off clients, but plain trunk forwarding never stalls
      @(negedge clk) chk(10'({client_rx_ready, trunk_rx_ready}), 10'h1);
      @(posedge clk) #1 stall = 2'h2;
      for (int i = 0; i < 4; i++) begin
         d = nxt();
         send(1'b1, rnd[9:8], d, 2'h2, d, d);
      end
      drain();
      // Every code on every port, with and without maintenance
      alarm_raw = 5'h1F;
      for (int p = 0; p < 5; p++) begin
         for (int k = 0; k < 8; k++) begin
            alarm_in_loop = p[0];
            cfg(10'(k[1:0]) << (2 * p), k[2] ? 5'h1F : 5'h0, 5'h0);
            t = k[2] && k[1:0] == 2'h2;
            f = k[2] && k[1:0] == 2'h1;
            chk(10'({terminal_loop_condition[p], line_loop_condition[p], alarm_out[p],
                     out_of_service_loop_maint[p], alarms_suppressed_maint[p]}),
                10'({t, f, !((t | f) & !p[0]), t | f, (t | f) & !p[0]}));
         end
      end
      // Trunk facility loop, bridged then terminated
      d = nxt();
      cfg(10'h100, 5'h1F, 5'h0);
      chk({client_squelch, path_alarm_indication, 2'h0}, 10'h168);
      send(1'b1, 2'h1, d, 2'h2, d, 8'hFF);
      send(1'b1, 2'h0, d, 2'h0, d, d);
      cfg(10'h100, 5'h1F, 5'h10);
      send(1'b1, 2'h3, d, 2'h0, d, d);
      // Client facility loop, bridged then terminated
      cfg(10'h004, 5'h1F, 5'h0);
      send(1'b0, 2'h1, d, 2'h1, d, d);
      cfg(10'h004, 5'h1F, 5'h02);
      send(1'b0, 2'h1, d, 2'h1, 8'hFF, d);
      // Trunk terminal loop on the aggregate; an out-of-service client bypasses it
      cfg(10'h200, 5'h1F, 5'h0);
      send(1'b0, 2'h3, d, 2'h3, d, d);
      send(1'b1, 2'h2, d, 2'h0, d, d);
      in_service_normal = 5'h1D;
      send(1'b0, 2'h1, d, 2'h1, d, d);
      send(1'b1, 2'h1, d, 2'h2, d, d);
      in_service_normal = 5'h1F;
      // Client terminal loops on an Ethernet and a SONET client
      cfg(10'h00A, 5'h1F, 5'h0);
      chk({client_squelch, path_alarm_indication, 2'h0}, 10'h048);
      send(1'b1, 2'h1, d, 2'h3, d, 8'hFF);
      send(1'b1, 2'h0, d, 2'h1, d, d);
      drain();
      stop_test();
   end
endmodule

`default_nettype wire
